// ---- logic/pmu_pkg.sv ----
// Shared constants for the power sequencer: register map, field layout, timing
package pmu_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLOCK_HZ       = 40_000_000;
	localparam int MS_PER_SEC     = 1000;
	localparam int PWRUP_DELAY_MS = 15;
	localparam int STEP_DELAY_MS  = 2;
	localparam int SLEEP_GUARD_MS = 1000;
	localparam int MS_W           = 10;

	// ----------------------------------------------------------------
	// Register offsets (7-bit address)
	// ----------------------------------------------------------------
	localparam int        ADDR_W          = 7;
	localparam int        DATA_W          = 8;
	localparam bit [6:0]  OFS_REG3_LEVEL  = 7'h00;
	localparam bit [6:0]  OFS_SLEEP_LEVEL = 7'h09;
	localparam bit [6:0]  OFS_REG_CTRL    = 7'h0a;
	localparam bit [6:0]  OFS_COMP_CTRL   = 7'h0b;
	localparam bit [6:0]  OFS_IRQ_ENABLE  = 7'h0c;
	localparam bit [6:0]  OFS_IRQ_STATUS  = 7'h0d;
	localparam bit [6:0]  OFS_SLEEP_POL   = 7'h0e;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_REG1_EN      = 0;
	localparam int BIT_REG2_EN      = 1;
	localparam int BIT_IRQ_POLARITY = 0;
	localparam int BIT_SLEEP        = 1;
	localparam int BIT_HYST_DOUBLE  = 7;
	localparam int THRESH_W         = 7;
	localparam int NUM_IRQ          = 5;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam bit [7:0] RST_SLEEP_LEVEL = 8'h00;
	localparam bit [7:0] RST_REG_CTRL    = 8'h03;
	localparam bit [7:0] RST_COMP_CTRL   = 8'h19;
	localparam bit [7:0] RST_IRQ_ENABLE  = 8'h00;
	localparam bit [7:0] RST_SLEEP_POL   = 8'h00;
	localparam bit [7:0] CODE_REG3_1V2   = 8'h00;
	localparam bit [7:0] CODE_REG3_1V0   = 8'h01;

	// ----------------------------------------------------------------
	// Serial frame layout
	// ----------------------------------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int CNT_W      = 5;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_RESET      = 4'h0,
		S_PWRUP_WAIT = 4'h1,
		S_LDO        = 4'h2,
		S_REG1       = 4'h3,
		S_REG2       = 4'h4,
		S_ACTIVE     = 4'h5,
		S_SLP_REG3   = 4'h6,
		S_SLP_REG2   = 4'h7,
		S_SLP_REG1   = 4'h8,
		S_SLEEP      = 4'h9,
		S_WAKE_REG1  = 4'ha
	} seq_state_t;

endpackage : pmu_pkg

// ---- logic/reg_access_if.sv ----
// Register access carrier between the serial slave and the register file
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
	logic       wr_en;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport slave_side (output wr_en, output addr, output wdata, input rdata);
	modport regs_side  (input wr_en, input addr, input wdata, output rdata);
endinterface : reg_access_if
`default_nettype wire

// ---- logic/ms_delay_timer.sv ----
// Millisecond delay timer, restarted at every new sequence step
`timescale 1ns/100ps
`default_nettype none
module ms_delay_timer #(
	parameter int CYCLES_PER_MS = pmu_pkg::CLOCK_HZ / pmu_pkg::MS_PER_SEC
) (
	// Clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   rst_n_i,
	// Control
	input  wire logic                   start_i,
	input  wire logic [pmu_pkg::MS_W-1:0] target_ms_i,
	output logic                        done_o
);
	localparam int PRE_W = $clog2(CYCLES_PER_MS + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYCLES_PER_MS - 1);

	logic [PRE_W-1:0]         pre_q;
	logic [pmu_pkg::MS_W-1:0] ms_q;

	assign done_o = (ms_q == target_ms_i);

	// Prescaler and ms count both restart so a step never inherits a partial ms
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || start_i) begin
			pre_q <= '0;
			ms_q  <= '0;
		end else if (!done_o) begin
			if (pre_q == PRE_LAST) begin
				pre_q <= '0;
				ms_q  <= ms_q + 1'b1;
			end else begin
				pre_q <= pre_q + 1'b1;
			end
		end
	end
endmodule : ms_delay_timer
`default_nettype wire

// ---- logic/spi_reg_slave.sv ----
// Serial register port: 16-bit frames, read flag, 7-bit address, 8-bit data
`timescale 1ns/100ps
`default_nettype none
module spi_reg_slave (
	// Clock and reset
	input  wire logic     clock_i,
	input  wire logic     rst_n_i,
	// Serial pins
	input  wire logic     spi_cs_n_i,
	input  wire logic     spi_sclk_i,
	input  wire logic     spi_mosi_i,
	output logic          spi_miso_o,
	output logic          spi_miso_oe_o,
	// Register side
	reg_access_if.slave_side regs
);
	logic [2:0]                 sync1_q;
	logic [2:0]                 sync2_q;
	logic                       sclk_prev_q;
	logic [pmu_pkg::CNT_W-1:0]  cnt_q;
	logic [14:0]                rx_q;
	logic [7:0]                 tx_q;
	logic                       wr_q;
	logic                       rd_q;
	logic                       cs_act;
	logic                       rise;
	logic                       fall;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sync1_q     <= 3'h1;
			sync2_q     <= 3'h1;
			sclk_prev_q <= 1'b0;
		end else begin
			sync1_q     <= {spi_mosi_i, spi_sclk_i, spi_cs_n_i};
			sync2_q     <= sync1_q;
			sclk_prev_q <= sync2_q[1];
		end
	end

	assign cs_act = !sync2_q[0];
	assign rise   = cs_act && sync2_q[1] && !sclk_prev_q;
	assign fall   = cs_act && !sync2_q[1] && sclk_prev_q;

	// ----------------------------------------------------------------
	// Shift engine
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !cs_act) begin
			cnt_q <= '0;
			rx_q  <= '0;
			tx_q  <= '0;
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			if (rise) begin
				rx_q  <= {rx_q[13:0], sync2_q[2]};
				cnt_q <= cnt_q + 1'b1;
				// Direction is kept apart, the shift register moves on under it
				if (cnt_q == pmu_pkg::CNT_W'(0))
					rd_q <= sync2_q[2];
				// Read data is fetched once the address is complete
				if (cnt_q == pmu_pkg::CNT_W'(7))
					tx_q <= regs.rdata;
				if (cnt_q == pmu_pkg::CNT_W'(pmu_pkg::FRAME_BITS - 1))
					wr_q <= !rx_q[14];
			end else if (fall && cnt_q > pmu_pkg::CNT_W'(8)) begin
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end

	assign regs.wr_en   = wr_q;
	assign regs.addr    = (cnt_q == pmu_pkg::CNT_W'(7)) ? {rx_q[5:0], sync2_q[2]} : rx_q[14:8];
	assign regs.wdata   = rx_q[7:0];
	assign spi_miso_o   = tx_q[7];
	assign spi_miso_oe_o = cs_act && rd_q && cnt_q >= pmu_pkg::CNT_W'(8);
endmodule : spi_reg_slave
`default_nettype wire

// ---- logic/pmu_sequencer_sleep_irq.sv ----
// Power sequencer: start-up, sleep entry/exit, lockouts, registers and interrupt pin
`timescale 1ns/100ps
`default_nettype none
module pmu_sequencer_sleep_irq #(
	parameter int CYCLES_PER_MS = pmu_pkg::CLOCK_HZ / pmu_pkg::MS_PER_SEC
) (
	// Clock and power-on reset
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	// Control pins
	input  wire logic       reset_pin_n_i,
	input  wire logic       sleep_request_pin_i,
	input  wire logic       alt_level_select_two_i,
	input  wire logic       alt_level_select_three_i,
	// Supply and die monitors
	input  wire logic       undervoltage_lockout_i,
	input  wire logic       overvoltage_lockout_i,
	input  wire logic       thermal_shutdown_i,
	// Analog status
	input  wire logic [2:0] power_good_i,
	input  wire logic       ldo_power_good_i,
	input  wire logic       compare_input_pin_above_i,
	// Serial register port
	input  wire logic       spi_cs_n_i,
	input  wire logic       spi_sclk_i,
	input  wire logic       spi_mosi_i,
	output logic            spi_miso_o,
	output logic            spi_miso_oe_o,
	// Regulator controls
	output logic            ldo_enable_o,
	output logic [2:0]      regulator_enable_o,
	output logic [1:0]      discharge_enable_o,
	output logic            regulator2_high_level_o,
	output logic [7:0]      regulator3_code_o,
	output logic            pulse_frequency_mode_o,
	output logic            clocks_stop_o,
	// Comparator controls
	output logic [6:0]      compare_threshold_o,
	output logic            compare_hyst_double_o,
	// Interrupt pin
	output logic            irq_o
);
	localparam int NSYNC = 12;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sync1_q <= 12'h001;
			sync2_q <= 12'h001;
		end else begin
			sync1_q <= {compare_input_pin_above_i, ldo_power_good_i, power_good_i,
				thermal_shutdown_i, overvoltage_lockout_i, undervoltage_lockout_i,
				alt_level_select_three_i, alt_level_select_two_i, sleep_request_pin_i,
				reset_pin_n_i};
			sync2_q <= sync1_q;
		end
	end

	logic       reset_pin_n;
	logic       sleep_pin;
	logic       sel_two;
	logic       sel_three;
	logic       fault;
	logic [4:0] live_status;

	assign reset_pin_n = sync2_q[0];
	assign sleep_pin   = sync2_q[1];
	assign sel_two     = sync2_q[2];
	assign sel_three   = sync2_q[3];
	assign fault       = |sync2_q[6:4];
	assign live_status = sync2_q[11:7];

	// ----------------------------------------------------------------
	// Sequencer state and timers
	// ----------------------------------------------------------------
	pmu_pkg::seq_state_t      state_q;
	pmu_pkg::seq_state_t      state_d;
	logic                     step_start;
	logic                     step_done;
	logic                     guard_done;
	logic [pmu_pkg::MS_W-1:0] step_ms;
	logic                     moved_q;
	logic                     moved_d;
	logic                     sel_two_q;
	logic                     sel_three_q;

	assign step_start = (state_d != state_q);
	assign step_ms    = (state_q == pmu_pkg::S_PWRUP_WAIT) ?
		pmu_pkg::MS_W'(pmu_pkg::PWRUP_DELAY_MS) : pmu_pkg::MS_W'(pmu_pkg::STEP_DELAY_MS);

	ms_delay_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_step_timer (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.start_i     (step_start),
		.target_ms_i (step_ms),
		.done_o      (step_done)
	);

	// Guard restarts while held in reset, so it measures from power-up
	ms_delay_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_guard_timer (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.start_i     (state_q == pmu_pkg::S_RESET),
		.target_ms_i (pmu_pkg::MS_W'(pmu_pkg::SLEEP_GUARD_MS)),
		.done_o      (guard_done)
	);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	reg_access_if bus ();

	spi_reg_slave u_spi (
		.clock_i       (clock_i),
		.rst_n_i       (rst_n_i),
		.spi_cs_n_i    (spi_cs_n_i),
		.spi_sclk_i    (spi_sclk_i),
		.spi_mosi_i    (spi_mosi_i),
		.spi_miso_o    (spi_miso_o),
		.spi_miso_oe_o (spi_miso_oe_o),
		.regs          (bus.slave_side)
	);

	logic [7:0] reg3_level_q;
	logic [7:0] sleep_level_q;
	logic [7:0] reg_ctrl_q;
	logic [7:0] comp_ctrl_q;
	logic [7:0] irq_enable_q;
	logic [7:0] sleep_pol_q;
	logic       regs_clear;
	logic [7:0] reg3_default;

	// Lockouts and the reset pin both bring every register back to default
	assign regs_clear   = !rst_n_i || fault || !reset_pin_n;
	assign reg3_default = sel_three_q ? pmu_pkg::CODE_REG3_1V2 : pmu_pkg::CODE_REG3_1V0;

	always_ff @(posedge clock_i) begin
		if (regs_clear) begin
			reg3_level_q  <= reg3_default;
			sleep_level_q <= pmu_pkg::RST_SLEEP_LEVEL;
			reg_ctrl_q    <= pmu_pkg::RST_REG_CTRL;
			comp_ctrl_q   <= pmu_pkg::RST_COMP_CTRL;
			irq_enable_q  <= pmu_pkg::RST_IRQ_ENABLE;
			sleep_pol_q   <= pmu_pkg::RST_SLEEP_POL;
		end else if (state_q == pmu_pkg::S_LDO) begin
			// Level straps are only just latched, so refresh the default here
			reg3_level_q <= reg3_default;
		end else if (bus.wr_en) begin
			unique case (bus.addr)
				pmu_pkg::OFS_REG3_LEVEL:  reg3_level_q  <= bus.wdata;
				pmu_pkg::OFS_SLEEP_LEVEL: sleep_level_q <= bus.wdata;
				pmu_pkg::OFS_REG_CTRL:    reg_ctrl_q    <= bus.wdata;
				pmu_pkg::OFS_COMP_CTRL:   comp_ctrl_q   <= bus.wdata;
				pmu_pkg::OFS_IRQ_ENABLE:  irq_enable_q  <= bus.wdata;
				pmu_pkg::OFS_SLEEP_POL:   sleep_pol_q   <= bus.wdata;
				default: ;
			endcase
		end
	end

	// Status is read live; a read has no side effect on it or on the pin
	always_comb begin
		unique case (bus.addr)
			pmu_pkg::OFS_REG3_LEVEL:  bus.rdata = reg3_level_q;
			pmu_pkg::OFS_SLEEP_LEVEL: bus.rdata = sleep_level_q;
			pmu_pkg::OFS_REG_CTRL:    bus.rdata = reg_ctrl_q;
			pmu_pkg::OFS_COMP_CTRL:   bus.rdata = comp_ctrl_q;
			pmu_pkg::OFS_IRQ_ENABLE:  bus.rdata = irq_enable_q;
			pmu_pkg::OFS_IRQ_STATUS:  bus.rdata = {3'h0, live_status};
			pmu_pkg::OFS_SLEEP_POL:   bus.rdata = sleep_pol_q;
			default:                  bus.rdata = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Level straps
	// ----------------------------------------------------------------
	// Only the power-on reset clears the straps; they are re-taken at each start-up
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sel_two_q   <= 1'b0;
			sel_three_q <= 1'b1;
		end else if (state_q == pmu_pkg::S_PWRUP_WAIT && step_done) begin
			sel_two_q   <= sel_two;
			sel_three_q <= sel_three;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	logic both_off;

	assign both_off = !reg_ctrl_q[pmu_pkg::BIT_REG1_EN] && !reg_ctrl_q[pmu_pkg::BIT_REG2_EN];

	always_comb begin
		state_d = state_q;
		moved_d = moved_q;
		if (fault) begin
			state_d = pmu_pkg::S_RESET;
		end else begin
			unique case (state_q)
				pmu_pkg::S_RESET:      state_d = pmu_pkg::S_PWRUP_WAIT;
				pmu_pkg::S_PWRUP_WAIT: if (step_done) state_d = pmu_pkg::S_LDO;
				pmu_pkg::S_LDO:        if (step_done) state_d = pmu_pkg::S_REG1;
				pmu_pkg::S_REG1:       if (step_done) state_d = pmu_pkg::S_REG2;
				pmu_pkg::S_REG2:       if (step_done) state_d = pmu_pkg::S_ACTIVE;
				pmu_pkg::S_ACTIVE: begin
					if (guard_done && sleep_pin) begin
						if (both_off) begin
							moved_d = 1'b0;
							state_d = pmu_pkg::S_SLEEP;
						end else begin
							moved_d = 1'b1;
							state_d = pmu_pkg::S_SLP_REG3;
						end
					end
				end
				pmu_pkg::S_SLP_REG3:  if (step_done) state_d = pmu_pkg::S_SLP_REG2;
				pmu_pkg::S_SLP_REG2:  if (step_done) state_d = pmu_pkg::S_SLP_REG1;
				pmu_pkg::S_SLP_REG1:  state_d = pmu_pkg::S_SLEEP;
				pmu_pkg::S_SLEEP:     if (!sleep_pin) state_d = pmu_pkg::S_WAKE_REG1;
				pmu_pkg::S_WAKE_REG1: if (step_done) state_d = pmu_pkg::S_ACTIVE;
				default:              state_d = pmu_pkg::S_RESET;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_q <= pmu_pkg::S_RESET;
			moved_q <= 1'b0;
		end else begin
			state_q <= state_d;
			moved_q <= moved_d;
		end
	end

	// ----------------------------------------------------------------
	// Regulator drive
	// ----------------------------------------------------------------
	logic ldo_on;
	logic reg1_allowed;
	logic reg2_allowed;
	logic reg3_on;
	logic reg3_at_sleep;
	logic sleep_mode;
	logic reg1_en;
	logic reg2_en;

	always_comb begin
		ldo_on        = 1'b0;
		reg1_allowed  = 1'b0;
		reg2_allowed  = 1'b0;
		reg3_on       = 1'b0;
		reg3_at_sleep = 1'b0;
		unique case (state_q)
			pmu_pkg::S_RESET, pmu_pkg::S_PWRUP_WAIT: ;
			pmu_pkg::S_LDO: ldo_on = 1'b1;
			pmu_pkg::S_REG1: begin
				ldo_on       = 1'b1;
				reg1_allowed = 1'b1;
			end
			pmu_pkg::S_REG2: begin
				ldo_on       = 1'b1;
				reg1_allowed = 1'b1;
				reg2_allowed = 1'b1;
			end
			pmu_pkg::S_ACTIVE: begin
				ldo_on       = 1'b1;
				reg1_allowed = 1'b1;
				reg2_allowed = 1'b1;
				reg3_on      = 1'b1;
			end
			pmu_pkg::S_SLP_REG3: begin
				ldo_on        = 1'b1;
				reg1_allowed  = 1'b1;
				reg2_allowed  = 1'b1;
				reg3_on       = 1'b1;
				reg3_at_sleep = 1'b1;
			end
			pmu_pkg::S_SLP_REG2, pmu_pkg::S_WAKE_REG1: begin
				ldo_on        = 1'b1;
				reg1_allowed  = 1'b1;
				reg3_on       = 1'b1;
				reg3_at_sleep = moved_q;
			end
			pmu_pkg::S_SLP_REG1, pmu_pkg::S_SLEEP: begin
				ldo_on        = 1'b1;
				reg3_on       = 1'b1;
				reg3_at_sleep = moved_q;
			end
			default: ;
		endcase
	end

	// Linear regulator ignores software enables; only lockouts stop it
	assign reg1_en    = reg1_allowed && reg_ctrl_q[pmu_pkg::BIT_REG1_EN];
	assign reg2_en    = reg2_allowed && reg_ctrl_q[pmu_pkg::BIT_REG2_EN];
	assign sleep_mode = (state_q == pmu_pkg::S_SLEEP) || sleep_pol_q[pmu_pkg::BIT_SLEEP];

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			ldo_enable_o            <= 1'b0;
			regulator_enable_o      <= 3'h0;
			discharge_enable_o      <= 2'h3;
			regulator2_high_level_o <= 1'b0;
			regulator3_code_o       <= pmu_pkg::CODE_REG3_1V2;
			pulse_frequency_mode_o  <= 1'b0;
			clocks_stop_o           <= 1'b0;
		end else begin
			ldo_enable_o            <= ldo_on;
			regulator_enable_o      <= {reg3_on, reg2_en, reg1_en};
			discharge_enable_o      <= {!reg2_en, !reg1_en};
			regulator2_high_level_o <= sel_two_q;
			regulator3_code_o       <= reg3_at_sleep ? sleep_level_q : reg3_level_q;
			pulse_frequency_mode_o  <= sleep_mode;
			clocks_stop_o           <= sleep_mode;
		end
	end

	// ----------------------------------------------------------------
	// Comparator settings and interrupt pin
	// ----------------------------------------------------------------
	logic irq_active;

	assign irq_active = |(live_status & irq_enable_q[pmu_pkg::NUM_IRQ-1:0]);

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			compare_threshold_o   <= pmu_pkg::RST_COMP_CTRL[pmu_pkg::THRESH_W-1:0];
			compare_hyst_double_o <= 1'b0;
			irq_o                 <= 1'b1;
		end else begin
			compare_threshold_o   <= comp_ctrl_q[pmu_pkg::THRESH_W-1:0];
			compare_hyst_double_o <= comp_ctrl_q[pmu_pkg::BIT_HYST_DOUBLE];
			irq_o <= sleep_pol_q[pmu_pkg::BIT_IRQ_POLARITY] ? irq_active : !irq_active;
		end
	end
endmodule : pmu_sequencer_sleep_irq
`default_nettype wire

// ---- sim/pmu_host_model.sv ----
// Host controller model: drives serial register frames
`timescale 1ns/100ps
`default_nettype none
module pmu_host_model (
	input  wire logic       clock_i,
	output var logic        cs_n_o,
	output var logic        sclk_o,
	output var logic        mosi_o,
	input  wire logic       miso_i,
	input  wire logic       oe_i,
	output var logic  [7:0] rdata_o,
	output var logic        rvalid_o
);
	initial begin
		{cs_n_o, sclk_o, mosi_o, rvalid_o} = 4'b1000;
		rdata_o = 8'h00;
	end
	// Five clocks per half period keeps the serial clock under a fifth of the core clock
	task automatic xfer(input logic [15:0] f);
		logic [7:0] q;
		@(negedge clock_i) cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_o = f[i];
			repeat (5) @(negedge clock_i);
			if (i < 8)
				q[i] = oe_i ? miso_i : 1'bx;
			sclk_o = 1'b1;
			repeat (5) @(negedge clock_i);
			sclk_o = 1'b0;
		end
		repeat (5) @(negedge clock_i);
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		if (f[15]) begin
			rdata_o = q;
			rvalid_o = 1'b1;
			@(negedge clock_i) rvalid_o = 1'b0;
		end
		repeat (5) @(negedge clock_i);
	endtask : xfer
endmodule : pmu_host_model
`default_nettype wire

// ---- sim/pmu_sequencer_sleep_irq_props.sv ----
// Concurrent checks on the sequencer's ports
`timescale 1ns/100ps
`default_nettype none
module pmu_seq_props #(
	parameter int CYCLES_PER_MS = 4
) (
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	input wire logic       undervoltage_lockout_i,
	input wire logic       overvoltage_lockout_i,
	input wire logic       thermal_shutdown_i,
	input wire logic       ldo_enable_o,
	input wire logic [2:0] regulator_enable_o,
	input wire logic [1:0] discharge_enable_o,
	input wire logic       regulator2_high_level_o,
	input wire logic       pulse_frequency_mode_o,
	input wire logic       clocks_stop_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	dis_path_a: assert property (discharge_enable_o == ~regulator_enable_o[1:0]) else $error("discharge");
	ldo_first_a: assert property (!ldo_enable_o |-> regulator_enable_o == 3'b000) else $error("ldo order");
	reg2_order_a: assert property ($rose(regulator_enable_o[1]) |-> $past(regulator_enable_o[0], 6))
		else $error("reg2 order");
	reg3_order_a: assert property ($rose(regulator_enable_o[2]) |-> $past(regulator_enable_o[1], 6))
		else $error("reg3 order");
	uv_off_a: assert property ($rose(undervoltage_lockout_i) |-> ##[1:6] regulator_enable_o == 3'b000)
		else $error("uv");
	ov_off_a: assert property ($rose(overvoltage_lockout_i) |-> ##[1:6] !ldo_enable_o) else $error("ov");
	tsd_off_a: assert property ($rose(thermal_shutdown_i) |-> ##[1:6] !ldo_enable_o) else $error("tsd");
	strap_hold_a: assert property (regulator_enable_o[1] && $past(regulator_enable_o[1])
		|-> $stable(regulator2_high_level_o)) else $error("strap");
	sleep_pfm_a: assert property (pulse_frequency_mode_o == clocks_stop_o) else $error("sleep");
endmodule : pmu_seq_props
bind pmu_sequencer_sleep_irq pmu_seq_props #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk (.clock_i, .rst_n_i,
	.undervoltage_lockout_i, .overvoltage_lockout_i, .thermal_shutdown_i, .ldo_enable_o,
	.regulator_enable_o, .discharge_enable_o, .regulator2_high_level_o, .pulse_frequency_mode_o, .clocks_stop_o);
`default_nettype wire

// ---- sim/pmu_sequencer_sleep_irq_tb.sv ----
// Self-checking bench for the power sequencer
`timescale 1ns/100ps
`default_nettype none
module pmu_sequencer_sleep_irq_tb;
	logic clock_i = 0, rst_n_i = 0, reset_pin_n_i = 1, sleep_request_pin_i = 0;
	logic alt_level_select_two_i = 0, alt_level_select_three_i = 1, undervoltage_lockout_i = 0;
	logic overvoltage_lockout_i = 0, thermal_shutdown_i = 0, ldo_power_good_i = 0, compare_input_pin_above_i = 0;
	logic [2:0] power_good_i = 0, regulator_enable_o;
	logic spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o, ldo_enable_o, rvalid, irq_o;
	logic regulator2_high_level_o, pulse_frequency_mode_o, clocks_stop_o, compare_hyst_double_o;
	logic [1:0] discharge_enable_o;
	logic [6:0] compare_threshold_o;
	logic [7:0] regulator3_code_o, rdata, code3, exp_q[$];
	logic [31:0] r;
	int n_mismatch = 0, tests_run = 0, seed = 32'h836735e8;
	initial forever #12.5 clock_i = ~clock_i;
	pmu_sequencer_sleep_irq #(.CYCLES_PER_MS(4)) dut (.clock_i, .rst_n_i, .reset_pin_n_i, .sleep_request_pin_i,
		.alt_level_select_two_i, .alt_level_select_three_i, .undervoltage_lockout_i, .overvoltage_lockout_i,
		.thermal_shutdown_i, .power_good_i, .ldo_power_good_i, .compare_input_pin_above_i, .spi_cs_n_i,
		.spi_sclk_i, .spi_mosi_i, .spi_miso_o, .spi_miso_oe_o, .ldo_enable_o, .regulator_enable_o,
		.discharge_enable_o, .regulator2_high_level_o, .regulator3_code_o, .pulse_frequency_mode_o,
		.clocks_stop_o, .compare_threshold_o, .compare_hyst_double_o, .irq_o);
	pmu_host_model host (.clock_i, .cs_n_o(spi_cs_n_i), .sclk_o(spi_sclk_i), .mosi_o(spi_mosi_i),
		.miso_i(spi_miso_o), .oe_i(spi_miso_oe_o), .rdata_o(rdata), .rvalid_o(rvalid));
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic wrap_up();
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.xfer({1'b1, a, 8'h00});
	endtask : rd
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer({1'b0, a, d});
	endtask : wr
	// Bounded wait for an enable pattern, then compare it
	task automatic w(input logic [2:0] e, input int n);
		for (int i = 0; i < n && regulator_enable_o !== e; i++)
			@(negedge clock_i);
		check("enables", regulator_enable_o, e);
	endtask : w
	always @(posedge clock_i)
		if (rvalid === 1'b1)
			check("read", rdata, exp_q.pop_front());
	initial begin
		repeat (20000) @(posedge clock_i);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		r = $random(seed);
		alt_level_select_two_i = r[0];
		alt_level_select_three_i = r[1];
		code3 = r[1] ? pmu_pkg::CODE_REG3_1V2 : pmu_pkg::CODE_REG3_1V0;
		repeat (5) @(negedge clock_i);
		rst_n_i = 1;
		w(3'b111, 200);
		check("level2", regulator2_high_level_o, r[0]);
		check("level3", regulator3_code_o, code3);
		sleep_request_pin_i = 1;
		repeat (20) @(negedge clock_i);
		check("guard", regulator_enable_o, 3'b111);
		sleep_request_pin_i = 0;
		alt_level_select_two_i = ~r[0];
		rd(pmu_pkg::OFS_REG_CTRL, pmu_pkg::RST_REG_CTRL);
		check("level2", regulator2_high_level_o, r[0]);
		rd(pmu_pkg::OFS_COMP_CTRL, pmu_pkg::RST_COMP_CTRL);
		rd(7'h7f, 8'h00);
		wr(pmu_pkg::OFS_REG_CTRL, 8'h02);
		w(3'b110, 20);
		check("discharge", discharge_enable_o, 2'b01);
		wr(pmu_pkg::OFS_REG_CTRL, 8'h03);
		r = $random(seed);
		{compare_input_pin_above_i, ldo_power_good_i, power_good_i} = r[4:0];
		wr(pmu_pkg::OFS_IRQ_STATUS, 8'hff);
		rd(pmu_pkg::OFS_IRQ_STATUS, {3'b000, r[4:0]});
		wr(pmu_pkg::OFS_IRQ_ENABLE, 8'h1f);
		check("irq", irq_o, ~|r[4:0]);
		wr(pmu_pkg::OFS_SLEEP_POL, 8'h01);
		check("irq", irq_o, |r[4:0]);
		wr(pmu_pkg::OFS_SLEEP_LEVEL, 8'h5a);
		repeat (4000) @(negedge clock_i);
		sleep_request_pin_i = 1;
		w(3'b100, 40);
		check("sleep code", regulator3_code_o, 8'h5a);
		repeat (2) @(negedge clock_i);
		check("pfm", pulse_frequency_mode_o, 1'b1);
		sleep_request_pin_i = 0;
		w(3'b111, 20);
		check("wake code", regulator3_code_o, code3);
		wr(pmu_pkg::OFS_REG_CTRL, 8'h00);
		wr(pmu_pkg::OFS_REG3_LEVEL, r[15:8]);
		sleep_request_pin_i = 1;
		repeat (30) @(negedge clock_i);
		check("pin sleep", pulse_frequency_mode_o, 1'b1);
		check("kept code", regulator3_code_o, r[15:8]);
		sleep_request_pin_i = 0;
		wr(pmu_pkg::OFS_SLEEP_POL, 8'h03);
		check("sw sleep", clocks_stop_o, 1'b1);
		wr(pmu_pkg::OFS_SLEEP_POL, 8'h01);
		check("sw wake", clocks_stop_o, 1'b0);
		// Regulator 1 first, so the start-up order check still sees it lead
		wr(pmu_pkg::OFS_REG_CTRL, 8'h01);
		wr(pmu_pkg::OFS_REG_CTRL, 8'h03);
		w(3'b111, 20);
		reset_pin_n_i = 0;
		repeat (5) @(negedge clock_i);
		reset_pin_n_i = 1;
		rd(pmu_pkg::OFS_IRQ_ENABLE, pmu_pkg::RST_IRQ_ENABLE);
		rd(pmu_pkg::OFS_SLEEP_LEVEL, pmu_pkg::RST_SLEEP_LEVEL);
		check("reset code", regulator3_code_o, code3);
		check("reset irq", irq_o, 1'b1);
		for (int k = 0; k < 3; k++) begin
			{thermal_shutdown_i, overvoltage_lockout_i, undervoltage_lockout_i} = 3'b001 << k;
			w(3'b000, 10);
			check("ldo", ldo_enable_o, 1'b0);
			{thermal_shutdown_i, overvoltage_lockout_i, undervoltage_lockout_i} = 3'b000;
			w(3'b111, 120);
		end
		wrap_up();
	end
endmodule : pmu_sequencer_sleep_irq_tb
`default_nettype wire
